/* hw/eerd_regs.vh */
`ifndef EERD_REGS_VH
`define EERD_REGS_VH
`define EERD_TYPE_ARRAY 4'ha
`define EERD_TYPE_ARRAY_B 4'b1010
`define EERD_TYPE_IDPG_B 4'b1011
`define EERD_ADDR_W 17
`define EERD_ARRAY_FILL 8'hff
`define EERD_ST_IDLE 4'h0
`define EERD_ST_SEL 4'h1
`define EERD_ST_SEL_ACK 4'h2
`define EERD_ST_ADDR 4'h3
`define EERD_ST_ADDR_ACK 4'h4
`define EERD_ST_DATA 4'h5
`define EERD_ST_DATA_ACK 4'h6
`define EERD_ST_TX 4'h7
`define EERD_ST_TX_ACK 4'h8
`define EERD_ST_WAITP 4'h9
`define EERD_ST_TX_NEXT 4'ha
`define EERD_FIFO_DEPTH 32
`endif

/* hw/eerd_fifo.v */
module eerd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  input wire flush
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  wire empty = (wp_q == rp_q);
  wire full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  always @* begin
    out_data = mem_q[rp_q[AW-1:0]];
  end
  always @(posedge clk) begin
    if (!rst_n || flush) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
  always @(posedge clk) begin
    if (in_valid && !full) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

/* hw/eerd_top.v */
`include "eerd_regs.vh"
module eerd_top #(
  parameter AW = 17,
  parameter FIFO_DEPTH = 32
) (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire chip_select_strap,
  input wire write_protect_input,
  input wire write_busy,
  input wire id_page_locked,
  output reg [AW-1:0] mem_addr,
  output reg mem_id_sel,
  output reg mem_rd_req,
  input wire [7:0] mem_rd_data,
  input wire mem_rd_valid,
  input wire mem_array_programmed,
  output reg [7:0] wr_byte,
  output reg wr_valid,
  input wire wr_ready,
  output reg [AW-1:0] addr_counter_q
);
  reg [1:0] scl_s_q;
  reg [1:0] sda_s_q;
  reg scl_q;
  reg sda_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
    end
  end
  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire scl_rise = scl && !scl_q;
  wire scl_fall = !scl && scl_q;
  wire start_c = scl && scl_q && sda_q && !sda;
  wire stop_c = scl && scl_q && !sda_q && sda;

  function sel_match;
    input [7:0] b;
    input strap;
    begin
      sel_match = ((b[7:4] == `EERD_TYPE_ARRAY_B) ||
        (b[7:4] == `EERD_TYPE_IDPG_B)) && (b[2] == strap);
    end
  endfunction

  // read address: id page uses only the low byte
  function [AW-1:0] rd_addr;
    input id;
    input [AW-1:0] cnt;
    begin
      if (id) begin
        rd_addr = {{(AW-8){1'b0}}, cnt[7:0]};
      end else begin
        rd_addr = cnt;
      end
    end
  endfunction

  // data byte ack: lock for id page, protect for array
  function data_ack;
    input id;
    input locked;
    input wp;
    begin
      if (id) begin
        data_ack = !locked;
      end else begin
        data_ack = !wp;
      end
    end
  endfunction

  // counter step: id page wraps in its own byte
  function [AW-1:0] next_addr;
    input id;
    input [AW-1:0] cnt;
    begin
      if (id) begin
        next_addr = {cnt[AW-1:8], cnt[7:0] + 8'd1};
      end else begin
        next_addr = cnt + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  reg [3:0] st_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg [1:0] abyte_q;
  reg id_q;
  reg rd_q;
  reg drv_q;
  reg [7:0] tx_q;
  reg [15:0] alat_q;
  reg a16_q;
  reg fetch_q;
  reg ackph_q;
  wire [7:0] rx = {sh_q[6:0], sda};

  wire [7:0] ff_out;
  wire ff_valid;
  wire ff_in_ready;
  reg ff_pop;
  eerd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(5)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(mem_array_programmed || mem_id_sel ? mem_rd_data :
      `EERD_ARRAY_FILL),
    .in_valid(mem_rd_valid),
    .in_ready(ff_in_ready),
    .out_data(ff_out),
    .out_valid(ff_valid),
    .out_ready(ff_pop),
    .flush(start_c || stop_c)
  );

  assign sda_out = 1'b0;
  assign sda_oe = drv_q;

  always @(posedge clk) begin
    if (!rst_n) begin
      st_q <= `EERD_ST_IDLE;
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      abyte_q <= 2'd0;
      id_q <= 1'b0;
      rd_q <= 1'b0;
      drv_q <= 1'b0;
      tx_q <= 8'hff;
      alat_q <= 16'h0000;
      a16_q <= 1'b0;
      addr_counter_q <= {AW{1'b0}};
      mem_addr <= {AW{1'b0}};
      mem_id_sel <= 1'b0;
      mem_rd_req <= 1'b0;
      fetch_q <= 1'b0;
      ackph_q <= 1'b0;
      wr_byte <= 8'h00;
      wr_valid <= 1'b0;
      ff_pop <= 1'b0;
    end else begin
      mem_rd_req <= 1'b0;
      ff_pop <= 1'b0;
      if (wr_valid && wr_ready) begin
        wr_valid <= 1'b0;
      end
      if (start_c) begin
        st_q <= `EERD_ST_SEL;
        bit_q <= 3'd0;
        drv_q <= 1'b0;
        fetch_q <= 1'b0;
        ackph_q <= 1'b0;
      end else if (stop_c) begin
        st_q <= `EERD_ST_IDLE;
        drv_q <= 1'b0;
        fetch_q <= 1'b0;
        ackph_q <= 1'b0;
      end else begin
        case (st_q)
          `EERD_ST_IDLE, `EERD_ST_WAITP: begin
            drv_q <= 1'b0;
          end
          `EERD_ST_SEL, `EERD_ST_ADDR, `EERD_ST_DATA: begin
            if (scl_rise) begin
              sh_q <= rx;
              bit_q <= bit_q + 3'd1;
              if (bit_q == 3'd7) begin
                if (st_q == `EERD_ST_SEL) begin
                  if (sel_match(rx, chip_select_strap) && !write_busy) begin
                    st_q <= `EERD_ST_SEL_ACK;
                    id_q <= (rx[7:4] == `EERD_TYPE_IDPG_B);
                    rd_q <= rx[0];
                    if (!rx[0]) begin
                      a16_q <= rx[1];
                    end
                  end else begin
                    st_q <= `EERD_ST_WAITP;
                  end
                end else if (st_q == `EERD_ST_ADDR) begin
                  st_q <= `EERD_ST_ADDR_ACK;
                  if (abyte_q == 2'd0) begin
                    alat_q[15:8] <= rx;
                  end else begin
                    alat_q[7:0] <= rx;
                    addr_counter_q <= {a16_q, alat_q[15:8], rx};
                  end
                end else begin
                  st_q <= `EERD_ST_DATA_ACK;
                  wr_byte <= rx;
                  wr_valid <= data_ack(id_q, id_page_locked,
                    write_protect_input);
                end
              end
            end
          end
          `EERD_ST_SEL_ACK, `EERD_ST_ADDR_ACK, `EERD_ST_DATA_ACK: begin
            if (scl_fall && !ackph_q) begin
              // ack slot opens: drive or withhold once
              ackph_q <= 1'b1;
              drv_q <= (st_q != `EERD_ST_DATA_ACK) ||
                data_ack(id_q, id_page_locked, write_protect_input);
              if (st_q == `EERD_ST_SEL_ACK && rd_q) begin
                // fetch at counter
                mem_addr <= rd_addr(id_q, addr_counter_q);
                mem_id_sel <= id_q;
                mem_rd_req <= ff_in_ready;
                fetch_q <= 1'b1;
              end
            end else if (scl_fall && !drv_q) begin
              // withheld ack: ignore bus until start
              ackph_q <= 1'b0;
              st_q <= `EERD_ST_WAITP;
            end else if (scl_fall) begin
              ackph_q <= 1'b0;
              drv_q <= 1'b0;
              bit_q <= 3'd0;
              if (st_q == `EERD_ST_SEL_ACK) begin
                abyte_q <= 2'd0;
                st_q <= rd_q ? `EERD_ST_TX : `EERD_ST_ADDR;
                if (rd_q) begin
                  tx_q <= ff_out;
                  drv_q <= !ff_out[7];
                  ff_pop <= 1'b1;
                end
              end else if (st_q == `EERD_ST_ADDR_ACK) begin
                abyte_q <= abyte_q + 2'd1;
                st_q <= (abyte_q == 2'd0) ? `EERD_ST_ADDR : `EERD_ST_DATA;
              end else begin
                st_q <= `EERD_ST_DATA;
              end
            end
          end
          `EERD_ST_TX_NEXT: begin
            // next byte leaves after master ack slot ends
            if (scl_fall) begin
              bit_q <= 3'd0;
              tx_q <= ff_out;
              drv_q <= !ff_out[7];
              ff_pop <= 1'b1;
              st_q <= `EERD_ST_TX;
            end
          end
          `EERD_ST_TX: begin
            if (scl_fall) begin
              bit_q <= bit_q + 3'd1;
              if (bit_q == 3'd7) begin
                drv_q <= 1'b0;
                st_q <= `EERD_ST_TX_ACK;
                // wrap by width
                addr_counter_q <= next_addr(id_q, addr_counter_q);
              end else begin
                drv_q <= !tx_q[3'd6 - bit_q];
              end
            end
          end
          `EERD_ST_TX_ACK: begin
            if (scl_rise) begin
              if (sda) begin
                st_q <= `EERD_ST_WAITP;
              end else begin
                // drive stays off while the clock is high
                mem_addr <= rd_addr(id_q, addr_counter_q);
                mem_rd_req <= ff_in_ready;
                st_q <= `EERD_ST_TX_NEXT;
              end
            end
          end
          default: begin
            st_q <= `EERD_ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

/* verification/eerd_chk_asserts.sv */
module eerd_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_busy,
  input wire logic mem_rd_req,
  input wire logic [7:0] wr_byte,
  input wire logic wr_valid,
  input wire logic wr_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_busy_noack;
    write_busy && $past(write_busy) |-> !$rose(sda_oe);
  endproperty
  a_busy_noack: assert property (p_busy_noack)
    else $error("select acked while busy");
  property p_busy_nofetch;
    write_busy |-> !mem_rd_req;
  endproperty
  a_busy_nofetch: assert property (p_busy_nofetch)
    else $error("fetch while busy");
  property p_req_pulse;
    mem_rd_req |=> !mem_rd_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("read request longer than one cycle");
  property p_oe_scl_high;
    scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  a_oe_scl_high: assert property (p_oe_scl_high)
    else $error("data drive changed with clock high");
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data output not low");
  property p_start_release;
    scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:4] !sda_oe;
  endproperty
  a_start_release: assert property (p_start_release)
    else $error("line held after start");
  property p_stop_idle;
    scl_in && $past(scl_in) && $rose(sda_in) |=> !sda_oe [*4];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("line driven after stop");
  property p_wr_hold;
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_byte);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("received byte dropped before taken");
endmodule
bind eerd_top eerd_chk u_chk (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .write_busy(write_busy), .mem_rd_req(mem_rd_req), .wr_byte(wr_byte),
  .wr_valid(wr_valid), .wr_ready(wr_ready));

/* verification/eerd_mem_model.sv */
module eerd_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_rd_req,
  input wire logic mem_id_sel,
  input wire logic [16:0] mem_addr,
  output logic [7:0] mem_rd_data,
  output logic mem_rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // data is address xor a per-page mask; stale data is scrambled
  always @(posedge clk) begin
    mem_rd_valid <= rst_n && mem_rd_req;
    if (mem_rd_req) begin
      mem_rd_data <= mem_addr[7:0] ^ (mem_id_sel ? 8'hc3 : 8'h5a);
    end else begin
      mem_rd_data <= ~mem_rd_data;
    end
  end
endmodule

/* verification/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, scl = 1, sda_m = 1, strap = 0, wp = 0;
  logic busy = 0, locked = 0, prog = 1, wr_ready = 1, a;
  logic [7:0] d;
  wire sda_oe, sda_out, mem_id_sel, mem_rd_req, mem_rd_valid, wr_valid;
  wire [16:0] mem_addr, cnt;
  wire [7:0] mem_rd_data, wr_byte;
  wire sda = sda_m & !sda_oe;
  int failures = 0, cmp_count = 0;
  always #50 clk = ~clk;
  eerd_top u_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_strap(strap),
    .write_protect_input(wp), .write_busy(busy), .id_page_locked(locked),
    .mem_addr(mem_addr), .mem_id_sel(mem_id_sel), .mem_rd_req(mem_rd_req),
    .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid),
    .mem_array_programmed(prog), .wr_byte(wr_byte), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .addr_counter_q(cnt));
  eerd_mem_model u_mem (.clk(clk), .rst_n(rst_n), .mem_rd_req(mem_rd_req),
    .mem_id_sel(mem_id_sel), .mem_addr(mem_addr),
    .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid));
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task bt(input logic b, output logic r);
    sda_m <= b; cyc(2); scl <= 1; cyc(2); r = sda; cyc(2); scl <= 0; cyc(2);
  endtask
  task start;
    sda_m <= 1; cyc(3); scl <= 1; cyc(3); sda_m <= 0; cyc(3); scl <= 0;
    cyc(2);
  endtask
  task stop;
    sda_m <= 0; cyc(2); scl <= 1; cyc(3); sda_m <= 1; cyc(3);
  endtask
  task wb(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bt(v[i], r);
    bt(1'b1, r);
    ack = !r;
  endtask
  task rb(input logic mack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bt(1'b1, v[i]);
    bt(!mack, r);
  endtask
  task chk(input logic [16:0] seen, input logic [16:0] exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task sel_addr(input logic [7:0] s, input logic [15:0] ad);
    wb(s, a);
    chk(a, 1, "select ack");
    wb(ad[15:8], a);
    wb(ad[7:0], a);
  endtask
  task print_verdict;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    cyc(20000);
    failures++;
    print_verdict;
  end
  initial begin
    cyc(8); rst_n <= 1; cyc(4);
    busy <= 1; start; wb(8'ha0, a);
    chk(a, 0, "busy select");
    stop; cyc(4); busy <= 0; wp <= 1;
    start; sel_addr(8'ha2, 16'hffff);
    start; wb(8'ha3, a);
    chk(a, 1, "read select");
    rb(1, d); chk(d, 8'ha5, "top byte");
    rb(0, d); chk(d, 8'h5a, "wrapped byte");
    stop; cyc(2); chk(cnt, 17'h0_0001, "counter");
    start; wb(8'ha1, a); rb(0, d);
    chk(d, 8'h5b, "current byte");
    bt(1'b1, a); chk(a, 1, "line released");
    stop; cyc(2); chk(cnt, 17'h0_0002, "counter");
    start; wb(8'ha4, a); chk(a, 0, "strap mismatch");
    stop; strap <= 1; wp <= 0;
    start; sel_addr(8'hb4, 16'h7f10);
    start; wb(8'hb5, a); rb(0, d);
    chk(d, 8'hd3, "id byte");
    stop;
    for (int k = 0; k < 2; k++) begin
      locked <= !k; wr_ready <= 0; cyc(2);
      start; sel_addr(8'hb4, 16'h0000); wb(8'h00, a);
      chk(a, k, "lock status");
      start; stop; cyc(4); wr_ready <= 1; cyc(4);
    end
    prog <= 0; start; wb(8'ha5, a); rb(0, d);
    chk(d, 8'hff, "blank byte");
    stop; cyc(4);
    print_verdict;
  end
endmodule
